// ===== rtl/bbf_defs.vh
// constants for the bidirectional byte fifo host controller
// assumes a 20 MHz controller clock and the device's port A pins
`ifndef BBF_DEFS_VH
`define BBF_DEFS_VH

// clock period in ns
`define BBF_CLK_NS          50
// address setup before a strobe falls, in ns and cycles (least time, round up)
`define BBF_SETUP_NS        50
`define BBF_SETUP_CYC       ((`BBF_SETUP_NS + `BBF_CLK_NS - 1) / `BBF_CLK_NS)
// strobe low width in ns and cycles; covers access time plus the pin synchroniser
`define BBF_LOW_NS          150
`define BBF_LOW_CYC         ((`BBF_LOW_NS + `BBF_CLK_NS - 1) / `BBF_CLK_NS)
// data hold after a strobe rises, in ns and cycles
`define BBF_HOLD_NS         50
`define BBF_HOLD_CYC        ((`BBF_HOLD_NS + `BBF_CLK_NS - 1) / `BBF_CLK_NS)

// register address 0 holds pointer (write) and status (read)
`define BBF_REG_POINTER     3'h0
`define BBF_REG_STATUS      3'h0
// pointer register fields
`define BBF_PTR_ADDR_MSB    2
`define BBF_PTR_FRAME_BIT   7

// user command codes
`define BBF_OP_FIFO_WR      4'h0
`define BBF_OP_FIFO_RD      4'h1
`define BBF_OP_PTR_WR       4'h2
`define BBF_OP_STAT_RD      4'h3
`define BBF_OP_REG_WR       4'h4
`define BBF_OP_REG_RD       4'h5
`define BBF_OP_FRAME_MARK   4'h6
`define BBF_OP_BYP_REG_WR   4'h7
`define BBF_OP_BYP_REG_RD   4'h8

// answer fifo shape
`define BBF_RSP_WIDTH       8
`define BBF_RSP_DEPTH       8

`endif

// ===== rtl/bbf_host.v
// host controller that drives port A of the bidirectional byte fifo device,
// plus the port B strobes and select needed for register access in bypass
// assumes the device pins are wired to these ports; two-way data is split
//
// Functional notes
// (R1) select high means register, low means fifo
// (R2) access starts on falling strobe edge
// (R3) interrupt clears when port reads its status
// (R4) other registers: pointer write, then access
// (R5) pointer and status share address zero
// (R6) pointer clears itself after second cycle
// (R7) fifo write data held around rising strobe
// (R8) fifo read data valid while strobe low
// (R9) two 512 by 9 buffers inside device
// (R10) device buffers have separate position counters
// (R11) port B parity generated on reads
// (R12) port B parity checked on writes
// (R13) pointer frame bit marks next byte only
// (R14) framed byte sets port B frame flag
// (R15) framing mode drives stored frame bit
// (R16) parity mode replaces frame bit, flag set
// (R17) port B marks reach port A checker
// (R18) bypass leaves fifo contents untouched
// (R19) bypass: A strobes move data across
// (R20) bypass: A select high reaches A registers
// (R21) bypass: B registers written by B strobe
// (R22) bypass: B registers read onto A bus
// (R23) device ignores writes full, reads empty
// (R24) frame bit is pointer bit seven, twice
`include "bbf_defs.vh"
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// answer fifo
// ----------------------------------------------------------------
module bbf_fifo #(
    parameter WIDTH = `BBF_RSP_WIDTH,
    parameter DEPTH = `BBF_RSP_DEPTH,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_pos;
    reg [AW-1:0]    rd_pos;
    reg [AW:0]      fill;
    wire            push;
    wire            pop;

    // honest full and empty from the fill count
    assign in_ready  = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data  = mem[rd_pos];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage writes
    always @(posedge clk) begin
        if (push) begin
            mem[wr_pos] <= in_data;
        end
    end

    // positions and fill count
    always @(posedge clk) begin
        if (!resetn) begin
            wr_pos <= {AW{1'b0}};
            rd_pos <= {AW{1'b0}};
            fill   <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_pos <= (wr_pos == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_pos + 1'b1;
            end
            if (pop) begin
                rd_pos <= (rd_pos == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_pos + 1'b1;
            end
            if (push && !pop) begin
                fill <= fill + 1'b1;
            end else if (pop && !push) begin
                fill <= fill - 1'b1;
            end
        end
    end
endmodule

// ----------------------------------------------------------------
// host sequencer
// ----------------------------------------------------------------
module bbf_host #(
    parameter SETUP_CYC = `BBF_SETUP_CYC,
    parameter LOW_CYC   = `BBF_LOW_CYC,
    parameter HOLD_CYC  = `BBF_HOLD_CYC
) (
    input  wire       clk,
    input  wire       resetn,
    input  wire       cmd_valid,
    output wire       cmd_ready,
    input  wire [3:0] cmd_op,
    input  wire [2:0] cmd_addr,
    input  wire [7:0] cmd_data,
    output wire       rsp_valid,
    input  wire       rsp_ready,
    output wire [7:0] rsp_data,
    output wire       busy,
    output wire       irq_pending,
    input  wire [7:0] dev_d_a_in,
    output reg  [7:0] dev_d_a_out,
    output reg        dev_d_a_oe,
    output reg        dev_rd_a_n,
    output reg        dev_wr_a_n,
    output reg        dev_cd_a,
    input  wire       dev_irq_a_n,
    output reg        dev_rd_b_n,
    output reg        dev_wr_b_n,
    output reg        dev_cd_b
);
    localparam S_IDLE  = 2'h0;
    localparam S_SETUP = 2'h1;
    localparam S_LOW   = 2'h2;
    localparam S_HOLD  = 2'h3;

    reg  [1:0] state;
    reg  [7:0] cnt;
    reg  [3:0] op;
    reg  [2:0] addr;
    reg  [7:0] data;
    reg        step;
    reg  [7:0] d_meta;
    reg  [7:0] d_sync;
    reg  [1:0] irq_sync;
    reg        st_read;
    reg        st_cd;
    reg        st_byp;
    reg        st_last;
    reg  [7:0] st_data;
    reg        push;
    wire       fifo_in_ready;
    wire       op_known;
    wire [7:0] ptr_word;

    // pointer word carrying a register address in its low bits
    assign ptr_word = {{(7-`BBF_PTR_ADDR_MSB){1'b0}}, addr};  // R4

    // pin synchronisers; first stage feeds only the second
    always @(posedge clk) begin
        if (!resetn) begin
            d_meta   <= 8'h00;
            d_sync   <= 8'h00;
            irq_sync <= 2'h3;
        end else begin
            d_meta   <= dev_d_a_in;
            d_sync   <= d_meta;
            irq_sync <= {irq_sync[0], dev_irq_a_n};
        end
    end

    // interrupt from port A stays until a status read clears it in the device
    assign irq_pending = !irq_sync[1];  // R3

    // step decode: what each step of the current command puts on the pins
    always @* begin
        st_read = 1'b0;
        st_cd   = 1'b0;
        st_byp  = 1'b0;
        st_last = 1'b1;
        st_data = data;
        case (op)
            `BBF_OP_FIFO_WR: begin
                st_cd = 1'b0;  // R1 R7
            end
            `BBF_OP_FIFO_RD: begin
                st_read = 1'b1;  // R8
            end
            `BBF_OP_PTR_WR: begin
                st_cd = 1'b1;  // R5
            end
            `BBF_OP_STAT_RD: begin
                st_cd   = 1'b1;  // R5
                st_read = 1'b1;  // R3
            end
            `BBF_OP_REG_WR: begin
                st_cd   = 1'b1;
                st_last = step;  // R4
                st_data = step ? data : ptr_word;
            end
            `BBF_OP_REG_RD: begin
                st_cd   = 1'b1;
                st_last = step;  // R4
                st_read = step;
                st_data = ptr_word;
            end
            `BBF_OP_FRAME_MARK: begin
                st_cd   = 1'b1;
                st_last = step;  // R24
                st_data = 8'h80 | ptr_word;  // R13
            end
            `BBF_OP_BYP_REG_WR: begin
                st_byp  = 1'b1;  // R21
                st_last = step;
                st_data = step ? data : ptr_word;
            end
            `BBF_OP_BYP_REG_RD: begin
                st_byp  = 1'b1;  // R22
                st_last = step;
                st_read = step;
                st_data = ptr_word;
            end
            default: st_last = 1'b1;
        endcase
    end

    assign op_known  = (cmd_op <= `BBF_OP_BYP_REG_RD);
    // a new command waits for room for its answer, so reads never drop data
    assign cmd_ready = (state == S_IDLE) && fifo_in_ready;
    assign busy      = (state != S_IDLE);

    // sequencer: setup, strobe low, hold, then next step or idle
    always @(posedge clk) begin
        if (!resetn) begin
            state       <= S_IDLE;
            cnt         <= 8'h00;
            op          <= 4'h0;
            addr        <= 3'h0;
            data        <= 8'h00;
            step        <= 1'b0;
            push        <= 1'b0;
            dev_d_a_out <= 8'h00;
            dev_d_a_oe  <= 1'b0;
            dev_rd_a_n  <= 1'b1;
            dev_wr_a_n  <= 1'b1;
            dev_cd_a    <= 1'b0;
            dev_rd_b_n  <= 1'b1;
            dev_wr_b_n  <= 1'b1;
            dev_cd_b    <= 1'b0;
        end else begin
            push <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (cmd_valid && cmd_ready && op_known) begin
                        op    <= cmd_op;
                        addr  <= cmd_addr;
                        data  <= cmd_data;
                        step  <= 1'b0;
                        cnt   <= SETUP_CYC[7:0];
                        state <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    // with SETUP_CYC of one, select, data and the held A strobe change on the same edge as the strobe falls
                    dev_cd_a    <= st_cd;  // R1 R20
                    dev_cd_b    <= st_byp;
                    dev_d_a_out <= st_data;
                    dev_d_a_oe  <= !st_read;
                    dev_wr_a_n  <= !(st_byp && !st_read);  // R21
                    dev_rd_a_n  <= !(st_byp && st_read);  // R22
                    if (cnt <= 8'h01) begin
                        cnt   <= LOW_CYC[7:0];
                        state <= S_LOW;
                        // falling edge starts the access in the device
                        if (st_byp) begin
                            dev_wr_b_n <= st_read;  // R21
                            dev_rd_b_n <= !st_read;  // R22
                        end else begin
                            dev_wr_a_n <= st_read;  // R2
                            dev_rd_a_n <= !st_read;  // R2
                        end
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                S_LOW: begin
                    if (cnt <= 8'h01) begin
                        // read data captured through the synchroniser before release
                        push <= st_read;  // R8
                        // rising edge latches write data; outputs stay for hold; bypass keeps A low
                        dev_wr_a_n <= dev_wr_a_n | !st_byp;  // R7
                        dev_rd_a_n <= dev_rd_a_n | !st_byp;
                        dev_wr_b_n <= 1'b1;
                        dev_rd_b_n <= 1'b1;
                        cnt        <= HOLD_CYC[7:0];
                        state      <= S_HOLD;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                S_HOLD: begin
                    if (cnt <= 8'h01) begin
                        if (st_byp && !(dev_wr_a_n && dev_rd_a_n)) begin
                            // bypass: A strobe rises a cycle after B, while data still drives
                            dev_wr_a_n <= 1'b1;  // R21 R22
                            dev_rd_a_n <= 1'b1;
                        end else if (st_last) begin
                            // device has cleared its pointer after a two-step access
                            dev_d_a_oe <= 1'b0;  // R6
                            dev_cd_a   <= 1'b0;
                            dev_cd_b   <= 1'b0;
                            state      <= S_IDLE;
                        end else begin
                            step  <= 1'b1;  // R4 R24
                            cnt   <= SETUP_CYC[7:0];
                            state <= S_SETUP;
                        end
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // answers to reads, held for the user with back-pressure
    bbf_fifo #(
        .WIDTH (`BBF_RSP_WIDTH),
        .DEPTH (`BBF_RSP_DEPTH),
        .AW    (3)
    ) u_rsp (
        .clk       (clk),
        .resetn    (resetn),
        .in_data   (d_sync),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .out_data  (rsp_data),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready)
    );
endmodule

`default_nettype wire

// ===== testbench/bbf_host_sva.sv
// checker for the byte fifo host controller pins and command port
// assumes default strobe timing and a bind from the bench top
`include "bbf_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module bbf_host_sva #(
    parameter LOW_CYC = `BBF_LOW_CYC
) (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [3:0] cmd_op,
    input wire logic       irq_pending,
    input wire logic [7:0] dev_d_a_out,
    input wire logic       dev_d_a_oe,
    input wire logic       dev_rd_a_n,
    input wire logic       dev_wr_a_n,
    input wire logic       dev_cd_a,
    input wire logic       dev_irq_a_n,
    input wire logic       dev_rd_b_n,
    input wire logic       dev_wr_b_n,
    input wire logic       dev_cd_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    int lo;
    // cycles that a port a strobe has been low
    always @(posedge clk) lo <= (!resetn || (dev_rd_a_n && dev_wr_a_n)) ? 0 : lo + 1;
    sequence b_wr_pulse; !dev_wr_b_n [*3] ##1 dev_wr_b_n; endsequence
    sequence b_rd_pulse; !dev_rd_b_n [*3] ##1 dev_rd_b_n; endsequence
    strobe_excl_a: assert property (dev_rd_a_n || dev_wr_a_n)
        else $error("both a strobes low");
    strobe_width_a: assert property (($rose(dev_rd_a_n) || $rose(dev_wr_a_n))
        && !$past(dev_cd_b) |-> lo == LOW_CYC) else $error("strobe width wrong");
    wr_drive_a: assert property (!dev_wr_a_n |-> dev_d_a_oe)
        else $error("write without data");
    wr_hold_a: assert property ($rose(dev_wr_a_n) |-> dev_d_a_oe && $stable(dev_d_a_out))
        else $error("write data not held");
    rd_float_a: assert property (!dev_rd_a_n |-> !dev_d_a_oe)
        else $error("bus driven in read");
    byp_wr_a: assert property ($fell(dev_wr_b_n) |->
        (dev_cd_b && !dev_cd_a && !dev_wr_a_n) throughout b_wr_pulse) else $error("b write bad");
    byp_rd_a: assert property ($fell(dev_rd_b_n) |->
        (dev_cd_b && !dev_cd_a && !dev_rd_a_n) throughout b_rd_pulse) else $error("b read bad");
    b_quiet_a: assert property (!dev_cd_b |-> dev_rd_b_n && dev_wr_b_n)
        else $error("b strobe outside bypass");
    wr_start_a: assert property (cmd_valid && cmd_ready && cmd_op == `BBF_OP_FIFO_WR
        |-> ##[1:4] !dev_wr_a_n && !dev_cd_a) else $error("fifo write not started");
    irq_sync_a: assert property ($fell(dev_irq_a_n) |-> ##2 irq_pending)
        else $error("irq not seen");
endmodule
`default_nettype wire

// ===== testbench/bbf_dev_model.sv
// port a side of the byte fifo device plus port b register access in bypass; port a writes loop back to its reads
// assumes a clean two-way bus level computed by the bench
`timescale 1ns/10ps
`default_nettype none
module bbf_dev_model #(
    parameter DEPTH    = 512,
    parameter CMD_ADDR = 1,   // command register address, arbitrary
    parameter BYP_BIT  = 0    // bypass bit position, arbitrary
) (
    input  wire logic       dev_rd_a_n,
    input  wire logic       dev_wr_a_n,
    input  wire logic       dev_cd_a,
    input  wire logic       dev_rd_b_n,
    input  wire logic       dev_wr_b_n,
    input  wire logic       dev_cd_b,
    input  wire logic [7:0] dev_d_a_in,
    output logic      [7:0] m_out,
    output logic            dev_irq_a_n
);
    logic [8:0] mem[$];
    logic [7:0] regs[0:15]; // a registers 0..7, b registers 8..15
    logic [2:0] ptr[0:1] = '{3'h0, 3'h0};
    logic       fb = 1'b0;
    logic       arm = 1'b0;
    logic       seen = 1'b0;
    wire        byp = regs[CMD_ADDR][BYP_BIT] === 1'b1;
    initial m_out = 8'h00;
    initial dev_irq_a_n = 1'b1;
    // pointer at address 0, otherwise addressed register then pointer clears
    task automatic reg_wr(input int p);
        if (ptr[p] != 3'h0) begin
            regs[p * 8 + ptr[p]] = dev_d_a_in;
            ptr[p] = 3'h0;
        end else begin
            if (p == 0 && arm && dev_d_a_in[7]) fb = 1'b1;
            arm = p == 0 && dev_d_a_in[7];
            ptr[p] = dev_d_a_in[2:0];
        end
    endtask
    // latch on rising strobe; in bypass data goes across, not stored
    always @(posedge dev_wr_a_n)
        if (dev_cd_a) reg_wr(0);
        else if (!byp && mem.size() < DEPTH) begin
            mem.push_back({fb, dev_d_a_in});
            fb = 1'b0;
        end
    always @(posedge dev_wr_b_n) if (byp && dev_cd_b) reg_wr(1);
    // drive after access time
    always @(negedge dev_rd_a_n) begin
        #20;
        if (dev_cd_a) m_out = ptr[0] != 0 ? regs[ptr[0]]
            : {mem.size() == DEPTH, mem.size() == 0, 5'h00, seen};
        else if (!byp && mem.size() > 0) m_out = mem[0][7:0];
    end
    always @(negedge dev_rd_b_n) begin
        #20;
        if (byp && dev_cd_b) m_out = regs[8 + ptr[1]];
    end
    // hold, then release the bus and advance
    always @(posedge dev_rd_a_n) begin
        #10;
        m_out = ~m_out;
        if (dev_cd_a && ptr[0] != 0) ptr[0] = 3'h0;
        else if (dev_cd_a) begin
            seen = 1'b0;
            dev_irq_a_n = 1'b1;
        end else if (!byp && mem.size() > 0) begin
            seen = seen | mem[0][8];
            if (mem[0][8]) dev_irq_a_n = 1'b0;
            void'(mem.pop_front());
        end
    end
    always @(posedge dev_rd_b_n) begin
        #10;
        m_out = ~m_out;
        if (byp && dev_cd_b) ptr[1] = 3'h0;
    end
endmodule
`default_nettype wire

// ===== testbench/bbf_host_tb.sv
// self-checking bench for the byte fifo host controller
// assumes the device model with a four byte store and default timing
`include "bbf_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module bbf_host_tb;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       cmd_valid = 1'b0;
    logic [3:0] cmd_op = 4'h0;
    logic [2:0] cmd_addr = 3'h0;
    logic [7:0] cmd_data = 8'h00;
    logic       rsp_ready = 1'b0;
    wire        cmd_ready, rsp_valid, busy, irq_pending, dev_d_a_oe, dev_irq_a_n;
    wire        dev_rd_a_n, dev_wr_a_n, dev_cd_a, dev_rd_b_n, dev_wr_b_n, dev_cd_b;
    wire  [7:0] rsp_data, dev_d_a_out, m_out, dev_d_a_in;
    int         n_mismatch = 0;
    int         check_count = 0;
    int         cyc = 0;
    assign dev_d_a_in = dev_d_a_oe ? dev_d_a_out : m_out; // bus level
    always #25 clk = ~clk;
    bbf_host bbf_host_i (.clk, .resetn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr,
        .cmd_data, .rsp_valid, .rsp_ready, .rsp_data, .busy, .irq_pending, .dev_d_a_in,
        .dev_d_a_out, .dev_d_a_oe, .dev_rd_a_n, .dev_wr_a_n, .dev_cd_a, .dev_irq_a_n,
        .dev_rd_b_n, .dev_wr_b_n, .dev_cd_b);
    bbf_dev_model #(.DEPTH(4)) bbf_dev_model_i (.dev_rd_a_n, .dev_wr_a_n, .dev_cd_a,
        .dev_rd_b_n, .dev_wr_b_n, .dev_cd_b, .dev_d_a_in, .m_out, .dev_irq_a_n);
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // offer one command, then wait for the sequencer to go idle
    task automatic cmd(input logic [3:0] op, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (!busy) break;
        end
    endtask
    task automatic rd(input logic [3:0] op, input logic [2:0] a, input logic [7:0] exp);
        cmd(op, a, 8'h00);
        for (int i = 0; i < 8 && !rsp_valid; i++) begin
            @(posedge clk);
            #1;
        end
        chk(rsp_data, exp);
        @(posedge clk);
        rsp_ready <= 1'b1;
        @(posedge clk);
        rsp_ready <= 1'b0;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            results();
        end
    end
    // main sequence
    initial begin
        repeat (19) @(posedge clk);
        #1;
        chk({dev_rd_a_n, dev_wr_a_n, dev_rd_b_n, dev_wr_b_n, dev_cd_a, dev_cd_b, dev_d_a_oe,
            rsp_valid}, 8'hf0);
        chk({6'h00, cmd_ready, busy}, 8'h02);
        @(posedge clk);
        resetn <= 1'b1;
        cmd(`BBF_OP_REG_WR, 3'h3, 8'h5a);
        rd(`BBF_OP_REG_RD, 3'h3, 8'h5a);
        rd(`BBF_OP_STAT_RD, 3'h0, 8'h40);
        cmd(`BBF_OP_FIFO_WR, 3'h0, 8'h11);
        cmd(`BBF_OP_FRAME_MARK, 3'h0, 8'h00);
        cmd(`BBF_OP_FIFO_WR, 3'h0, 8'h22);
        cmd(`BBF_OP_FIFO_WR, 3'h0, 8'h33);
        rd(`BBF_OP_FIFO_RD, 3'h0, 8'h11);
        chk({7'h0, irq_pending}, 8'h00);
        rd(`BBF_OP_FIFO_RD, 3'h0, 8'h22);
        chk({7'h0, irq_pending}, 8'h01);
        rd(`BBF_OP_FIFO_RD, 3'h0, 8'h33);
        rd(`BBF_OP_STAT_RD, 3'h0, 8'h41);
        chk({7'h0, irq_pending}, 8'h00);
        for (int i = 0; i < 5; i++) cmd(`BBF_OP_FIFO_WR, 3'h0, 8'(i));
        rd(`BBF_OP_STAT_RD, 3'h0, 8'h80);
        for (int i = 0; i < 4; i++) rd(`BBF_OP_FIFO_RD, 3'h0, 8'(i));
        rd(`BBF_OP_STAT_RD, 3'h0, 8'h40);
        cmd(`BBF_OP_FIFO_WR, 3'h0, 8'h77);
        cmd(`BBF_OP_REG_WR, 3'h1, 8'h01);
        cmd(`BBF_OP_BYP_REG_WR, 3'h2, 8'ha5);
        rd(`BBF_OP_BYP_REG_RD, 3'h2, 8'ha5);
        cmd(`BBF_OP_FIFO_WR, 3'h0, 8'h99);
        cmd(`BBF_OP_REG_WR, 3'h1, 8'h00);
        rd(`BBF_OP_FIFO_RD, 3'h0, 8'h77);
        rd(`BBF_OP_STAT_RD, 3'h0, 8'h40);
        cmd(4'hf, 3'h0, 8'h00);
        chk({7'h0, rsp_valid}, 8'h00);
        results();
    end
endmodule
bind bbf_host bbf_host_sva #(.LOW_CYC(LOW_CYC)) bbf_host_sva_i (.clk, .resetn, .cmd_valid,
    .cmd_ready, .cmd_op, .irq_pending, .dev_d_a_out, .dev_d_a_oe, .dev_rd_a_n, .dev_wr_a_n,
    .dev_cd_a, .dev_irq_a_n, .dev_rd_b_n, .dev_wr_b_n, .dev_cd_b);
`default_nettype wire
